// File: rtl/icsp_if.sv
// two-wire bus between master and converter slave, open-drain resolved
`timescale 1ns/100ps
interface icsp_if;
    logic scl;
    logic sda;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;

    // pull-ups: a line is low only while someone drives a zero
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

    modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
        output m_sda_o, output m_sda_oe);
    modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : icsp_if

// File: rtl/icsp_master.sv
// bus master end: byte-level command port, makes scl by dividing clk
`timescale 1ns/100ps
module icsp_master (
    // bus
    icsp_if.master bus,
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic cmd_ready,
    // response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);

    // ==========================================================
    // synchronisers and quarter-period timer
    logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
    icsp_pkg::icsp_hst_t st_r, st_nxt;
    logic [7:0] q_r, q_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bits_r, bits_nxt;
    logic [8:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic sclp_r, sclp_nxt, sdap_r, sdap_nxt;
    logic own_r, own_nxt;
    logic rdy_nxt, rv_nxt, rack_nxt;
    logic [7:0] rd_nxt;

    wire qend = q_r == icsp_pkg::QUARTER_CYC - 8'h01;
    wire take = cmd_valid & cmd_ready;
    wire bus_idle = scl_s2_r & sda_s2_r;

    // ==========================================================
    // sequencer: sda only moves a quarter away from scl edges
    always_comb
    begin
        st_nxt = st_r;
        q_nxt = qend ? 8'h00 : q_r + 8'h01;
        ph_nxt = qend ? ph_r + 2'h1 : ph_r;
        bits_nxt = bits_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        sclp_nxt = sclp_r;
        sdap_nxt = sdap_r;
        own_nxt = own_r;
        rdy_nxt = cmd_ready;
        rv_nxt = 1'b0;
        rd_nxt = rsp_data;
        rack_nxt = rsp_ack;
        case (st_r)
            icsp_pkg::H_IDLE:
            begin
                q_nxt = 8'h00;
                ph_nxt = 2'h0;
                bits_nxt = 4'h0;
                rdy_nxt = 1'b1;
                if (take)
                begin
                    rdy_nxt = 1'b0;
                    tx_nxt = {cmd_data, 1'b1};
                    if (cmd_op == icsp_pkg::OP_START)
                        st_nxt = icsp_pkg::H_BUS;
                    else if (!own_r)
                        rdy_nxt = 1'b1;
                    else if (cmd_op == icsp_pkg::OP_WRITE)
                        st_nxt = icsp_pkg::H_BITS;
                    else if (cmd_op == icsp_pkg::OP_READ)
                    begin
                        tx_nxt = {8'hff, cmd_last};
                        st_nxt = icsp_pkg::H_BITS;
                    end
                    else
                        st_nxt = icsp_pkg::H_STOP;
                end
            end
            icsp_pkg::H_BUS:
            begin
                q_nxt = 8'h00;
                ph_nxt = 2'h0;
                if (own_r || bus_idle)
                begin
                    sdap_nxt = 1'b0;
                    st_nxt = icsp_pkg::H_START;
                end
            end
            icsp_pkg::H_START:
            begin
                if (qend && ph_r == 2'h0)
                    sclp_nxt = 1'b0;
                else if (qend && ph_r == 2'h1)
                    sdap_nxt = 1'b1;
                else if (qend && ph_r == 2'h3)
                begin
                    // address byte goes out straight after START
                    sclp_nxt = 1'b1;
                    own_nxt = 1'b1;
                    st_nxt = icsp_pkg::H_BITS;
                end
            end
            icsp_pkg::H_BITS:
            begin
                if (qend && ph_r == 2'h0 &&
                    bits_r == icsp_pkg::FRAME_BITS)
                begin
                    sdap_nxt = 1'b0;
                    st_nxt = icsp_pkg::H_IDLE;
                    rdy_nxt = 1'b1;
                    rv_nxt = 1'b1;
                    rd_nxt = rx_r[8:1];
                    rack_nxt = ~rx_r[0];
                end
                else if (qend && ph_r == 2'h0)
                    sdap_nxt = ~tx_r[8];
                else if (qend && ph_r == 2'h1)
                    sclp_nxt = 1'b0;
                else if (qend && ph_r == 2'h2)
                    rx_nxt = {rx_r[7:0], sda_s2_r};
                else if (qend)
                begin
                    sclp_nxt = 1'b1;
                    tx_nxt = {tx_r[7:0], 1'b1};
                    bits_nxt = bits_r + 4'h1;
                end
            end
            icsp_pkg::H_STOP:
            begin
                if (qend && ph_r == 2'h0)
                    sdap_nxt = 1'b1;
                else if (qend && ph_r == 2'h1)
                    sclp_nxt = 1'b0;
                else if (qend && ph_r == 2'h2)
                    sdap_nxt = 1'b0;
                else if (qend)
                begin
                    own_nxt = 1'b0;
                    rdy_nxt = 1'b1;
                    st_nxt = icsp_pkg::H_IDLE;
                end
            end
            default:
                st_nxt = icsp_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r} <= 4'hf;
            st_r <= icsp_pkg::H_IDLE;
            q_r <= 8'h00;
            ph_r <= 2'h0;
            bits_r <= 4'h0;
            tx_r <= 9'h1ff;
            rx_r <= 9'h000;
            sclp_r <= 1'b0;
            sdap_r <= 1'b0;
            own_r <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_ack <= 1'b0;
        end
        else
        begin
            {scl_s1_r, scl_s2_r} <= {bus.scl, scl_s1_r};
            {sda_s1_r, sda_s2_r} <= {bus.sda, sda_s1_r};
            st_r <= st_nxt;
            q_r <= q_nxt;
            ph_r <= ph_nxt;
            bits_r <= bits_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            sclp_r <= sclp_nxt;
            sdap_r <= sdap_nxt;
            own_r <= own_nxt;
            cmd_ready <= rdy_nxt;
            rsp_valid <= rv_nxt;
            rsp_data <= rd_nxt;
            rsp_ack <= rack_nxt;
        end
    end

    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe = sclp_r;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = sdap_r;

endmodule : icsp_master

// File: rtl/icsp_pkg.sv
// constants, opcodes and state types for the converter two-wire slave port
// Contract
// - one bit per clock, data stable while high
// - idle bus: nobody pulls either line
// - master starts only on an idle bus; the master here also restarts when it already holds the bus (own_r set)
// - data falling, clock high: START
// - data rising, clock high: STOP
// - any byte count, nine clocks per byte
// - addressed receiving device acknowledges every byte
// - master receiver acknowledges all but last
// - acknowledger holds data low through high
// - master ends read: no acknowledge, STOP
// - device releases data after withheld acknowledge
// - address byte first after every START
// - address bits 7..4 must be 1001
// - address bits 3..1 match select pins
// - address bit 0: 0 write, 1 read
// - internal oscillator clocks conversion and refresh
// - select low: internal oscillator, driven out
// - select high: pin released, external clock used
// - first write byte control, next DAC data
// - conversion starts after read-address acknowledge
// - first byte read after reset is 80h
package icsp_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int QUARTER_NS = 2500;
    localparam logic [7:0] QUARTER_CYC = 8'(QUARTER_NS / CLK_PERIOD_NS);
    localparam int OSC_HALF_NS = 500;
    localparam logic [7:0] OSC_HALF_CYC = 8'(OSC_HALF_NS / CLK_PERIOD_NS);
    localparam logic [3:0] CONV_TICKS = 4'h8;

    // ==========================================================
    // address byte and frame layout
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam int ADDR_FIXED_LSB = 4;
    localparam int ADDR_SEL_LSB = 1;
    localparam int ADDR_RW_BIT = 0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    localparam logic [7:0] ADC_POR_VALUE = 8'h80;

    // ==========================================================
    // host command opcodes
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_STOP = 2'h3;

    typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK}
        icsp_dst_t;
    typedef enum logic [2:0] {H_IDLE, H_BUS, H_START, H_BITS, H_STOP}
        icsp_hst_t;

endpackage : icsp_pkg

// File: rtl/icsp_slave.sv
// converter slave end: bus engine on link_clk, converter side on clk
`timescale 1ns/100ps
module icsp_slave (
    // bus
    icsp_if.slave bus,
    // clocks and reset
    input wire logic link_clk,
    input wire logic clk,
    input wire logic rst_n,
    // straps
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit2,
    input wire logic clock_source_select,
    // oscillator pin
    input wire logic oscillator_pin_in,
    output logic oscillator_pin_out,
    output logic oscillator_pin_oe,
    // converter side
    input wire logic [7:0] adc_sample,
    output logic [7:0] ctrl_byte,
    output logic [7:0] dac_byte,
    output logic write_pulse,
    output logic conv_busy,
    output logic refresh_pulse
);

    // ==========================================================
    // link domain: pin synchronisers
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic [2:0] asel_s1_r, asel_s2_r;
    logic rt_s1_r, rt_s2_r, rt_d_r;
    logic res_tgl_r;
    logic [7:0] res_c_r;
    logic [7:0] res_l_r;

    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
            asel_s1_r <= 3'h0;
            asel_s2_r <= 3'h0;
            rt_s1_r <= 1'b0;
            rt_s2_r <= 1'b0;
            rt_d_r <= 1'b0;
            res_l_r <= icsp_pkg::ADC_POR_VALUE;
        end
        else
        begin
            scl_s1_r <= bus.scl;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= bus.sda;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
            asel_s1_r <= {addr_select_bit2, addr_select_bit1,
                addr_select_bit0};
            asel_s2_r <= asel_s1_r;
            rt_s1_r <= res_tgl_r;
            rt_s2_r <= rt_s1_r;
            rt_d_r <= rt_s2_r;
            // word is held still on the clk side for many cycles
            if (rt_s2_r ^ rt_d_r)
                res_l_r <= res_c_r;
        end
    end

    wire scl_rise = scl_s2_r & ~scl_d_r;
    wire scl_fall = ~scl_s2_r & scl_d_r;
    wire scl_hi = scl_s2_r & scl_d_r;
    wire start_det = scl_hi & sda_d_r & ~sda_s2_r;
    wire stop_det = scl_hi & ~sda_d_r & sda_s2_r;

    // ==========================================================
    // link domain: bus engine
    icsp_pkg::icsp_dst_t st_r, st_nxt;
    logic [3:0] bcnt_r, bcnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic pull_r, pull_nxt;
    logic first_r, first_nxt;
    logic rd_r, rd_nxt;
    logic widx_r, widx_nxt;
    logic [7:0] ctl_l_r, ctl_l_nxt;
    logic [7:0] dac_l_r, dac_l_nxt;
    logic wr_tgl_r, wr_tgl_nxt;
    logic cv_tgl_r, cv_tgl_nxt;

    wire addr_hit = (sh_r[7:icsp_pkg::ADDR_FIXED_LSB] ==
        icsp_pkg::ADDR_FIXED) &&
        (sh_r[3:icsp_pkg::ADDR_SEL_LSB] == asel_s2_r);
    wire byte_done = scl_fall && (bcnt_r == icsp_pkg::BYTE_BITS);

    always_comb
    begin
        st_nxt = st_r;
        bcnt_nxt = bcnt_r;
        sh_nxt = sh_r;
        pull_nxt = pull_r;
        first_nxt = first_r;
        rd_nxt = rd_r;
        widx_nxt = widx_r;
        ctl_l_nxt = ctl_l_r;
        dac_l_nxt = dac_l_r;
        wr_tgl_nxt = wr_tgl_r;
        cv_tgl_nxt = cv_tgl_r;
        if (start_det)
        begin
            // address byte always follows a START
            st_nxt = icsp_pkg::D_RECV;
            bcnt_nxt = 4'h0;
            pull_nxt = 1'b0;
            first_nxt = 1'b1;
            widx_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            st_nxt = icsp_pkg::D_IDLE;
            pull_nxt = 1'b0;
        end
        else
        begin
            case (st_r)
                icsp_pkg::D_RECV:
                begin
                    if (scl_rise && bcnt_r != icsp_pkg::BYTE_BITS)
                    begin
                        sh_nxt = {sh_r[6:0], sda_s2_r};
                        bcnt_nxt = bcnt_r + 4'h1;
                    end
                    else if (byte_done && first_r)
                    begin
                        first_nxt = 1'b0;
                        rd_nxt = sh_r[icsp_pkg::ADDR_RW_BIT];
                        if (addr_hit)
                        begin
                            pull_nxt = 1'b1;
                            st_nxt = icsp_pkg::D_ACK;
                        end
                        else
                            st_nxt = icsp_pkg::D_IDLE;
                    end
                    else if (byte_done)
                    begin
                        // later bytes keep landing in the DAC register
                        if (!widx_r)
                            ctl_l_nxt = sh_r;
                        else
                            dac_l_nxt = sh_r;
                        widx_nxt = 1'b1;
                        wr_tgl_nxt = ~wr_tgl_r;
                        pull_nxt = 1'b1;
                        st_nxt = icsp_pkg::D_ACK;
                    end
                end
                icsp_pkg::D_ACK:
                begin
                    // low held until the acknowledge clock falls
                    if (scl_fall)
                    begin
                        bcnt_nxt = 4'h0;
                        if (rd_r)
                        begin
                            cv_tgl_nxt = ~cv_tgl_r;
                            sh_nxt = res_l_r;
                            pull_nxt = ~res_l_r[7];
                            st_nxt = icsp_pkg::D_SEND;
                        end
                        else
                        begin
                            pull_nxt = 1'b0;
                            st_nxt = icsp_pkg::D_RECV;
                        end
                    end
                end
                icsp_pkg::D_SEND:
                begin
                    if (scl_fall && bcnt_r == icsp_pkg::BYTE_BITS - 4'h1)
                    begin
                        pull_nxt = 1'b0;
                        st_nxt = icsp_pkg::D_MACK;
                    end
                    else if (scl_fall)
                    begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        pull_nxt = ~sh_r[6];
                        bcnt_nxt = bcnt_r + 4'h1;
                    end
                end
                icsp_pkg::D_MACK:
                begin
                    if (scl_rise && sda_s2_r)
                        st_nxt = icsp_pkg::D_IDLE;
                    else if (scl_rise)
                        st_nxt = icsp_pkg::D_ACK;
                end
                default:
                    st_nxt = icsp_pkg::D_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= icsp_pkg::D_IDLE;
            bcnt_r <= 4'h0;
            sh_r <= 8'h00;
            pull_r <= 1'b0;
            first_r <= 1'b0;
            rd_r <= 1'b0;
            widx_r <= 1'b0;
            ctl_l_r <= 8'h00;
            dac_l_r <= 8'h00;
            wr_tgl_r <= 1'b0;
            cv_tgl_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            bcnt_r <= bcnt_nxt;
            sh_r <= sh_nxt;
            pull_r <= pull_nxt;
            first_r <= first_nxt;
            rd_r <= rd_nxt;
            widx_r <= widx_nxt;
            ctl_l_r <= ctl_l_nxt;
            dac_l_r <= dac_l_nxt;
            wr_tgl_r <= wr_tgl_nxt;
            cv_tgl_r <= cv_tgl_nxt;
        end
    end

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = pull_r;

    // ==========================================================
    // clk domain: crossings, oscillator, conversion
    logic wt_s1_r, wt_s2_r, wt_d_r;
    logic ct_s1_r, ct_s2_r, ct_d_r;
    logic sel_s1_r, sel_s2_r;
    logic osi_s1_r, osi_s2_r, osi_d_r;
    logic [7:0] odiv_r;
    logic osc_r;
    logic [3:0] ccnt_r;
    logic [7:0] samp_r;

    wire odiv_end = odiv_r == icsp_pkg::OSC_HALF_CYC - 8'h01;
    wire int_tick = odiv_end & ~osc_r;
    wire ext_tick = osi_s2_r & ~osi_d_r;
    wire tick = sel_s2_r ? ext_tick : int_tick;
    wire conv_go = ct_s2_r ^ ct_d_r;
    wire conv_end = conv_busy && tick &&
        (ccnt_r == icsp_pkg::CONV_TICKS - 4'h1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {wt_s1_r, wt_s2_r, wt_d_r} <= 3'h0;
            {ct_s1_r, ct_s2_r, ct_d_r} <= 3'h0;
            {sel_s1_r, sel_s2_r} <= 2'h0;
            {osi_s1_r, osi_s2_r, osi_d_r} <= 3'h0;
            odiv_r <= 8'h00;
            osc_r <= 1'b0;
            oscillator_pin_out <= 1'b0;
            oscillator_pin_oe <= 1'b0;
            refresh_pulse <= 1'b0;
            ctrl_byte <= 8'h00;
            dac_byte <= 8'h00;
            write_pulse <= 1'b0;
        end
        else
        begin
            {wt_s1_r, wt_s2_r, wt_d_r} <= {wr_tgl_r, wt_s1_r, wt_s2_r};
            {ct_s1_r, ct_s2_r, ct_d_r} <= {cv_tgl_r, ct_s1_r, ct_s2_r};
            {sel_s1_r, sel_s2_r} <= {clock_source_select, sel_s1_r};
            {osi_s1_r, osi_s2_r, osi_d_r} <=
                {oscillator_pin_in, osi_s1_r, osi_s2_r};
            odiv_r <= odiv_end ? 8'h00 : odiv_r + 8'h01;
            if (odiv_end)
                osc_r <= ~osc_r;
            oscillator_pin_out <= osc_r;
            oscillator_pin_oe <= ~sel_s2_r;
            refresh_pulse <= tick;
            write_pulse <= wt_s2_r ^ wt_d_r;
            if (wt_s2_r ^ wt_d_r)
            begin
                ctrl_byte <= ctl_l_r;
                dac_byte <= dac_l_r;
            end
        end
    end

    // a new request restarts a conversion still in flight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_busy <= 1'b0;
            ccnt_r <= 4'h0;
            samp_r <= 8'h00;
            res_c_r <= icsp_pkg::ADC_POR_VALUE;
            res_tgl_r <= 1'b0;
        end
        else if (conv_go)
        begin
            conv_busy <= 1'b1;
            ccnt_r <= 4'h0;
            samp_r <= adc_sample;
        end
        else if (conv_end)
        begin
            conv_busy <= 1'b0;
            res_c_r <= samp_r;
            res_tgl_r <= ~res_tgl_r;
        end
        else if (conv_busy && tick)
            ccnt_r <= ccnt_r + 4'h1;
    end

endmodule : icsp_slave

// File: test/i2c_converter_slave_port_bench.sv
// bench: master end and converter slave joined on one bus
`timescale 1ns/100ps
module i2c_converter_slave_port_bench;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] dat;
        logic last;
        logic chk;
        logic ack;
        logic [7:0] exp;
    } icsp_row_t;
    localparam logic [1:0] ST = icsp_pkg::OP_START;
    localparam logic [1:0] WR = icsp_pkg::OP_WRITE;
    localparam logic [1:0] RD = icsp_pkg::OP_READ;
    localparam logic [1:0] SP = icsp_pkg::OP_STOP;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_last = 1'b0;
    logic cmd_ready, rsp_valid, rsp_ack, osc_out, osc_oe, osc_snap;
    logic [7:0] rsp_data, ctrl_byte, dac_byte;
    logic [2:0] sel = 3'h5;
    logic ext_sel = 1'b0;
    logic ext_clk = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int wr_pulses = 0;
    int conv_starts = 0;
    logic wr_pulse, busy;
    logic busy_q = 1'b0;
    // select pins 101: matching addresses 9a write, 9b read
    icsp_row_t rows [14] = '{
        '{ST, 8'h9a, 1'b0, 1'b1, 1'b1, 8'h9a},
        '{WR, 8'h3c, 1'b0, 1'b1, 1'b1, 8'h3c},
        '{WR, 8'h11, 1'b0, 1'b1, 1'b1, 8'h11},
        '{WR, 8'hc5, 1'b0, 1'b1, 1'b1, 8'hc5},
        '{SP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{ST, 8'h9b, 1'b0, 1'b1, 1'b1, 8'h9b},
        '{RD, 8'h00, 1'b0, 1'b1, 1'b1, 8'h80},
        '{RD, 8'h00, 1'b1, 1'b1, 1'b0, 8'h5a},
        '{SP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{ST, 8'h9c, 1'b0, 1'b1, 1'b0, 8'h9c},
        '{ST, 8'h9a, 1'b0, 1'b1, 1'b1, 8'h9a},
        '{SP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00},
        '{ST, 8'h8a, 1'b0, 1'b1, 1'b0, 8'h8a},
        '{SP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00}};

    icsp_if bus ();

    icsp_master i_icsp_master (.bus(bus.master), .clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    icsp_slave i_icsp_slave (.bus(bus.slave), .link_clk(link_clk),
        .clk(clk), .rst_n(rst_n), .addr_select_bit0(sel[0]),
        .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]),
        .clock_source_select(ext_sel), .oscillator_pin_in(ext_clk),
        .oscillator_pin_out(osc_out), .oscillator_pin_oe(osc_oe),
        .adc_sample(8'h5a), .ctrl_byte(ctrl_byte), .dac_byte(dac_byte),
        .write_pulse(wr_pulse), .conv_busy(busy), .refresh_pulse());
    icsp_properties i_icsp_properties (.clk(clk), .rst_n(rst_n),
        .scl(bus.scl), .sda(bus.sda), .m_scl_oe(bus.m_scl_oe),
        .m_sda_o(bus.m_sda_o), .s_sda_o(bus.s_sda_o),
        .s_sda_oe(bus.s_sda_oe));

    // ==========================================================
    // clocks: link clock free of any phase tie to clk
    initial forever #10 clk = ~clk;
    initial
    begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    initial forever #40 ext_clk = ~ext_clk;

    // output monitors, read away from the edge that launches them
    always @(negedge clk)
    begin
        if (wr_pulse === 1'b1)
            wr_pulses++;
        if (busy === 1'b1 && busy_q !== 1'b1)
            conv_starts++;
        busy_q = busy;
    end

    // ==========================================================
    // tasks
    task automatic check(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // bounded: a hung port ends the run as a mismatch
    task automatic wait_ready(input int limit);
        int n = 0;
        while (cmd_ready !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > limit)
            begin
                check("cmd_ready", 8'h01, {7'h0, cmd_ready});
                test_done();
            end
        end
    endtask : wait_ready

    task automatic send(input icsp_row_t r);
        wait_ready(20);
        cmd_op = r.op;
        cmd_data = r.dat;
        cmd_last = r.last;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        wait_ready(12000);
        check("rsp_valid", {7'h0, r.chk}, {7'h0, rsp_valid});
        if (r.chk)
        begin
            check("rsp_ack", {7'h0, r.ack}, {7'h0, rsp_ack});
            check("rsp_data", r.exp, rsp_data);
        end
    endtask : send

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i])
            send(rows[i]);
        check("ctrl_byte", 8'h3c, ctrl_byte);
        check("dac_byte", 8'hc5, dac_byte);
        check("wr_pulses", 8'h03, 8'(wr_pulses));
        check("conv_starts", 8'h02, 8'(conv_starts));
        osc_snap = osc_out;
        repeat (25) @(negedge clk);
        check("osc_oe", 8'h01, {7'h0, osc_oe});
        check("osc_out", {7'h0, ~osc_snap}, {7'h0, osc_out});
        ext_sel = 1'b1;
        repeat (10) @(negedge clk);
        check("osc_oe", 8'h00, {7'h0, osc_oe});
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        check("ctrl_byte", 8'h00, ctrl_byte);
        rst_n = 1'b1;
        // a write with no open transfer is dropped without a response
        send(icsp_row_t'{WR, 8'h55, 1'b0, 1'b0, 1'b0, 8'h00});
        check("rsp_data", 8'h00, rsp_data);
        @(negedge clk);
        send(icsp_row_t'{ST, 8'h9b, 1'b0, 1'b1, 1'b1, 8'h9b});
        send(icsp_row_t'{RD, 8'h00, 1'b1, 1'b1, 1'b0, 8'h80});
        send(icsp_row_t'{SP, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00});
        test_done();
    end
endmodule : i2c_converter_slave_port_bench

// File: test/icsp_properties.sv
// checker on the two-wire bus lines of the converter port
`timescale 1ns/100ps
module icsp_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus
    input wire logic scl,
    input wire logic sda,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic s_sda_o,
    input wire logic s_sda_oe
);
    // ==========================================================
    // properties, sampled on clk; scl phases last many cycles
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    scl_owner_a: assert property (!scl |-> m_scl_oe)
        else $error("scl low without master pull");
    open_drain_a: assert property (s_sda_oe |-> !s_sda_o && !m_sda_o)
        else $error("driven one on sda");
    ack_stable_a: assert property (
        scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("slave sda changed while scl high");
    slave_edge_a: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave moved sda while scl high");
    start_free_a: assert property (scl && $fell(sda) |-> !s_sda_oe)
        else $error("slave held sda at start");
    stop_free_a: assert property (scl && $rose(sda) |=> !s_sda_oe)
        else $error("slave pulled sda after stop");
    low_phase_a: assert property ($fell(scl) |=> !scl [*8])
        else $error("scl low phase too short");
    high_phase_a: assert property ($rose(scl) |=> scl [*8])
        else $error("scl high phase too short");
    idle_rest_a: assert property (scl && $rose(sda) |=> sda [*8])
        else $error("bus not idle after stop");

    cover property (scl && $fell(sda));
    cover property (scl && $rose(sda));
    cover property (scl && s_sda_oe);
endmodule : icsp_properties
